/* core/eec_pkg.sv */
package eec_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned US_HZ         = 1_000_000;
  localparam int unsigned US_CYCLES     = CLK_HZ / US_HZ;
  localparam int unsigned WRITE_TIME_US = 4000;

  // Array geometry
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned DEPTH     = 1024;
  localparam int unsigned ADDR_HI_W = 2;

  // Register byte offsets on the APB
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW   = 8'h04;
  localparam logic [7:0] OFF_ADDR_HIGH  = 8'h08;
  localparam logic [7:0] OFF_DATA       = 8'h0C;
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;

  // Interrupt status bit positions
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_WRITE_DONE = 0;
  localparam int unsigned IRQ_READ_DONE  = 1;
  localparam int unsigned IRQ_WRITE_ABRT = 2;

  // Reset values
  localparam logic [7:0]       RST_CONTROL = 8'h00;
  localparam logic [7:0]       RST_ADDR    = 8'h00;
  localparam logic [7:0]       RST_DATA    = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ     = 3'h0;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic program_memory_select;
    logic config_space_select;
    logic unused;
    logic row_erase;
    logic write_abort_flag;
    logic write_permit;
    logic write_trigger;
    logic read_trigger;
  } eec_ctrl_t;

  // Request to the storage array
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } eec_mem_req_t;

endpackage

/* core/eec_array.sv */
`timescale 1ns/1ps
module eec_array (
  // Clock
  input  wire logic                 clock,
  // Access
  input  wire eec_pkg::eec_mem_req_t req,
  output logic [7:0]                rd_data
);

  logic [7:0] mem [eec_pkg::DEPTH];

  // Byte write at cycle end
  always_ff @(posedge clock) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  // Read path settles within the cycle
  assign rd_data = mem[req.addr];

endmodule

/* core/eec_write_timer.sv */
`timescale 1ns/1ps
module eec_write_timer #(
  parameter int unsigned write_time_us = eec_pkg::WRITE_TIME_US
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      busy,
  output logic      done
);

  localparam int unsigned DIV_W = $clog2(eec_pkg::US_CYCLES);
  localparam int unsigned CNT_W = $clog2(write_time_us + 1);

  logic [DIV_W-1:0] div_reg;
  logic [CNT_W-1:0] left_reg;
  logic             tick;

  // Microsecond enable pulse while busy
  assign tick = busy && (div_reg == DIV_W'(eec_pkg::US_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || !busy || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  // Self-timed cycle length in microseconds
  always_ff @(posedge clock) begin
    if (rst || abort) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      left_reg <= '0;
    end else if (start && !busy) begin
      busy     <= 1'b1;
      done     <= 1'b0;
      left_reg <= CNT_W'(write_time_us);
    end else if (tick && left_reg <= CNT_W'(1)) begin
      busy     <= 1'b0;
      done     <= 1'b1;
      left_reg <= '0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        left_reg <= left_reg - CNT_W'(1);
      end
    end
  end

endmodule

/* core/eec_ctrl.sv */
// Operation
// - Write trigger starts timed erase/write cycle
// - Hardware clears write trigger at cycle end
// - Writing zero cannot abort running write
// - Read trigger reads in one cycle, self-clears
// - Read trigger set-only, ignored when program memory
// - Read byte ready for the next cycle
// - Data holds until next read, write or external reset
// - Ten-bit address, upper register two bits
// - External reset during write sets abort flag
// - Write completion sets flag software clears
`timescale 1ns/1ps
module eec_ctrl #(
  parameter int unsigned write_time_us = eec_pkg::WRITE_TIME_US
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Device reset sources, asynchronous pins
  input  wire logic        master_clear_reset,
  input  wire logic        watchdog_timeout,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Events
  output logic             irq,
  output logic             prog_write_strobe
);

  eec_pkg::eec_ctrl_t                  control_reg;
  logic [7:0]                          address_low_reg;
  logic [eec_pkg::ADDR_HI_W-1:0]       address_high_reg;
  logic [7:0]                          data_byte_reg;
  logic [eec_pkg::IRQ_W-1:0]           irq_status_reg;
  logic [eec_pkg::IRQ_W-1:0]           irq_status_next;
  logic [eec_pkg::IRQ_W-1:0]           irq_mask_reg;
  logic [1:0]                          master_clear_reset_sync_reg;
  logic [1:0]                          wdt_sync_reg;
  logic                                ext_reset;
  logic                                setup;
  logic                                wr_take;
  logic                                locked;
  logic                                rd_fire;
  logic                                wr_fire;
  logic                                tmr_busy;
  logic                                tmr_done;
  logic                                mem_commit;
  logic [7:0]                          rd_byte;
  eec_pkg::eec_mem_req_t               mem_req;
  eec_pkg::eec_ctrl_t                  wctl;
  logic [31:0]                         rd_word;

  // Register decode, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      eec_pkg::OFF_CONTROL,
      eec_pkg::OFF_ADDR_LOW,
      eec_pkg::OFF_ADDR_HIGH,
      eec_pkg::OFF_DATA,
      eec_pkg::OFF_UNLOCK_KEY,
      eec_pkg::OFF_IRQ_STATUS,
      eec_pkg::OFF_IRQ_MASK: is_mapped = 1'b1;
      default:               is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Two-flop synchronisers for external reset sources
  // Pins change at any time; the second flop bounds metastability
  always_ff @(posedge clock) begin
    if (rst) begin
      master_clear_reset_sync_reg <= 2'b00;
      wdt_sync_reg  <= 2'b00;
    end else begin
      master_clear_reset_sync_reg <= {master_clear_reset_sync_reg[0], master_clear_reset};
      wdt_sync_reg  <= {wdt_sync_reg[0], watchdog_timeout};
    end
  end

  assign ext_reset = master_clear_reset_sync_reg[1] || wdt_sync_reg[1];

  // APB phase decode
  assign setup   = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite && is_mapped(paddr);
  assign wctl    = eec_pkg::eec_ctrl_t'(pwdata[7:0]);

  // Control, address and data registers frozen while a write cycle runs
  // Address and byte must not shift under the cell being written
  // Timer busy rises with the trigger, so either one locks
  assign locked = control_reg.write_trigger || tmr_busy;

  // Read launch: set-only, refused for program memory
  assign rd_fire = wr_take && hit(paddr, eec_pkg::OFF_CONTROL) && !locked && !ext_reset
                   && wctl.read_trigger && !control_reg.program_memory_select;

  // Write launch: needs permit set beforehand, zero writes ignored
  // One write cannot both arm the permit and fire the cycle
  assign wr_fire = wr_take && hit(paddr, eec_pkg::OFF_CONTROL) && !locked && !ext_reset
                   && wctl.write_trigger && control_reg.write_permit;

  // Self-timed write cycle
  eec_write_timer #(
    .write_time_us (write_time_us)
  ) u_timer (
    .clock (clock),
    .rst   (rst),
    .start (wr_fire),
    .abort (ext_reset),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // Commit to data array only when data space is selected
  // An aborted cycle never raises done, so the cell stays untouched
  assign mem_commit = tmr_done && !control_reg.program_memory_select && !control_reg.config_space_select;

  assign mem_req.we    = mem_commit;
  assign mem_req.addr  = {address_high_reg, address_low_reg};
  assign mem_req.wdata = data_byte_reg;

  eec_array u_array (
    .clock   (clock),
    .req     (mem_req),
    .rd_data (rd_byte)
  );

  // Control register
  always_ff @(posedge clock) begin
    if (rst) begin
      control_reg <= eec_pkg::eec_ctrl_t'(eec_pkg::RST_CONTROL);
    end else if (ext_reset) begin
      if (control_reg.write_trigger) begin
        control_reg.write_abort_flag <= 1'b1;
      end
      control_reg.config_space_select <= 1'b0;
      control_reg.write_permit        <= 1'b0;
      control_reg.write_trigger       <= 1'b0;
      control_reg.read_trigger        <= 1'b0;
    end else begin
      // Read trigger lasts one cycle
      control_reg.read_trigger <= rd_fire;
      if (tmr_done) begin
        control_reg.write_trigger <= 1'b0;
      end else if (wr_fire) begin
        control_reg.write_trigger <= 1'b1;
      end
      if (wr_take && hit(paddr, eec_pkg::OFF_CONTROL) && !locked) begin
        // Triggers only settable, zero leaves them alone
        control_reg.program_memory_select <= wctl.program_memory_select;
        control_reg.config_space_select   <= wctl.config_space_select;
        control_reg.row_erase             <= wctl.row_erase;
        control_reg.write_abort_flag      <= wctl.write_abort_flag;
        control_reg.write_permit          <= wctl.write_permit;
      end
    end
  end

  // Address pair, ten bits
  always_ff @(posedge clock) begin
    if (rst || ext_reset) begin
      address_low_reg  <= eec_pkg::RST_ADDR;
      address_high_reg <= eec_pkg::RST_ADDR[eec_pkg::ADDR_HI_W-1:0];
    end else if (wr_take && !locked) begin
      if (hit(paddr, eec_pkg::OFF_ADDR_LOW)) begin
        address_low_reg <= pwdata[7:0];
      end
      if (hit(paddr, eec_pkg::OFF_ADDR_HIGH)) begin
        address_high_reg <= pwdata[eec_pkg::ADDR_HI_W-1:0];
      end
    end
  end

  // Data byte: loaded by a read or by software, else held
  always_ff @(posedge clock) begin
    if (rst || ext_reset) begin
      data_byte_reg <= eec_pkg::RST_DATA;
    end else if (rd_fire) begin
      data_byte_reg <= rd_byte;
    end else if (wr_take && !locked && hit(paddr, eec_pkg::OFF_DATA)) begin
      data_byte_reg <= pwdata[7:0];
    end
  end

  // Sticky events, set wins over write-one clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_take && hit(paddr, eec_pkg::OFF_IRQ_STATUS)) begin
      irq_status_next = irq_status_reg & ~pwdata[eec_pkg::IRQ_W-1:0];
    end
    if (tmr_done && !ext_reset) begin
      irq_status_next[eec_pkg::IRQ_WRITE_DONE] = 1'b1;
    end
    if (rd_fire) begin
      irq_status_next[eec_pkg::IRQ_READ_DONE] = 1'b1;
    end
    if (ext_reset && control_reg.write_trigger) begin
      irq_status_next[eec_pkg::IRQ_WRITE_ABRT] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status_reg <= eec_pkg::RST_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_mask_reg <= eec_pkg::RST_IRQ;
    end else if (wr_take && hit(paddr, eec_pkg::OFF_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[eec_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt from flop
  // Fed from the next status so it lines up with the sticky bits
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Program memory write completion strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      prog_write_strobe <= 1'b0;
    end else begin
      prog_write_strobe <= tmr_done && control_reg.program_memory_select;
    end
  end

  // APB ready: one wait-free access cycle after setup
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !is_mapped(paddr);
    end
  end

  // Readback word for the addressed register, unused bits zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      eec_pkg::OFF_CONTROL:    rd_word = {24'h00_0000, control_reg[7:6], 1'b0, control_reg[4:0]};
      eec_pkg::OFF_ADDR_LOW:   rd_word = {24'h00_0000, address_low_reg};
      eec_pkg::OFF_ADDR_HIGH:  rd_word = {30'h0000_0000, address_high_reg};
      eec_pkg::OFF_DATA:       rd_word = {24'h00_0000, data_byte_reg};
      eec_pkg::OFF_IRQ_STATUS: rd_word = {29'h0000_0000, irq_status_reg};
      eec_pkg::OFF_IRQ_MASK:   rd_word = {29'h0000_0000, irq_mask_reg};
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  // Read data captured at the setup edge
  // Held through the access cycle while pready stands
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_word;
    end
  end

endmodule

/* tb/eec_ctrl_monitor.sv */
`timescale 1ns/1ps
module eec_ctrl_monitor #(
  parameter int unsigned write_time_us = 4000
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        master_clear_reset,
  input wire logic        watchdog_timeout,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events
  input wire logic        irq,
  input wire logic        prog_write_strobe
);
  localparam int WCYC = write_time_us * eec_pkg::US_CYCLES;
  logic        wr_acc;
  logic [31:0] cnt;
  logic [7:0]  last_data;
  logic        last_ok;
  logic [2:0]  src_q;
  assign wr_acc = psel && penable && pready && pwrite;
  // Cycles since the last write trigger request
  always_ff @(posedge clock) begin
    if (rst) cnt <= 32'hFFFF_FFFF;
    else if (wr_acc && paddr == 8'h00 && pwdata[1]) cnt <= 32'h0000_0000;
    else if (cnt != 32'hFFFF_FFFF) cnt <= cnt + 32'h0000_0001;
  end
  // Last byte read from the data register, dropped on anything that may change it
  always_ff @(posedge clock) begin
    src_q <= {src_q[1:0], master_clear_reset | watchdog_timeout};
    if (rst || (wr_acc && (paddr == 8'h00 || paddr == 8'h0C)) || src_q != 3'h0 || master_clear_reset
        || watchdog_timeout) last_ok <= 1'b0;
    else if (pready && !pwrite && paddr == 8'h0C) last_ok <= 1'b1;
    if (pready && !pwrite && paddr == 8'h0C) last_data <= prdata[7:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_addr_high_bits; pready && !pwrite && paddr == 8'h08 |-> prdata[31:2] == 30'h0000_0000; endproperty
  a_addr_high_bits: assert property (p_addr_high_bits) else $error("address high unused bits set");
  property p_data_hold; pready && !pwrite && paddr == 8'h0C && last_ok |-> prdata[7:0] == last_data; endproperty
  a_data_hold: assert property (p_data_hold) else $error("data register changed unprompted");
  property p_irq_sticky; $fell(irq) |-> $past(wr_acc && (paddr == 8'h14 || paddr == 8'h18)); endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped without software");
  property p_strobe_timed; prog_write_strobe |-> cnt >= WCYC - 1; endproperty
  a_strobe_timed: assert property (p_strobe_timed) else $error("write ended too early");
  property p_strobe_pulse; prog_write_strobe |=> !prog_write_strobe; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("write strobe too long");
  property p_trig_clears; pready && !pwrite && paddr == 8'h00 && cnt > WCYC + 3 |-> !prdata[1]; endproperty
  a_trig_clears: assert property (p_trig_clears) else $error("write trigger stuck");
  // Main scenarios
  c_strobe: cover property (prog_write_strobe);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
endmodule
bind eec_ctrl eec_ctrl_monitor #(.write_time_us(write_time_us)) u_mon (
  .clock(clock), .rst(rst), .master_clear_reset(master_clear_reset), .watchdog_timeout(watchdog_timeout),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .prog_write_strobe(prog_write_strobe));

/* tb/eec_ctrl_tb.sv */
`timescale 1ns/1ps
module eec_ctrl_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} eec_row_t;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam int unsigned WR_US = 2;
  logic        clock, rst, master_clear_reset, watchdog_timeout, psel, penable, pwrite;
  logic        pready, pslverr, irq, prog_write_strobe, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          failures = 0, tests_run = 0, cyc = 0, strobes = 0, t0;
  eec_row_t    rows [8] = '{
    '{8'h04, 32'h0000_00A5, 32'h0000_00A5, 1'b0}, '{8'h08, 32'h0000_00FE, 32'h0000_0002, 1'b0},
    '{8'h0C, 32'h0000_003C, 32'h0000_003C, 1'b0}, '{8'h10, 32'h0000_0055, ZERO, 1'b0},
    '{8'h18, 32'h0000_0007, 32'h0000_0007, 1'b0}, '{8'h00, 32'h0000_00F4, 32'h0000_00D4, 1'b0},
    '{8'h1C, 32'h0000_00FF, ZERO, 1'b1}, '{8'h00, 32'h0000_0004, 32'h0000_0004, 1'b0}};

  eec_ctrl #(.write_time_us(WR_US)) DUT (
    .clock(clock), .rst(rst), .master_clear_reset(master_clear_reset), .watchdog_timeout(watchdog_timeout),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .prog_write_strobe(prog_write_strobe));

  // Clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Cycle and strobe counters
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (prog_write_strobe === 1'b1) strobes <= strobes + 1;
  end
  // Hang guard
  initial begin
    #(20000 * 25);
    failures++;
    summarize();
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) failures++;
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Poll the control register until the write trigger drops
  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      apb(1'b0, 8'h00, ZERO, r);
      if (r[1] === 1'b0) break;
    end
  endtask
  task automatic summarize();
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = ZERO;
    master_clear_reset = 1'b0; watchdog_timeout = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), ZERO, r);
      chk("reset value", r, ZERO);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, r);
      apb(1'b0, rows[i].a, ZERO, r);
      chk("readback", r, rows[i].e);
      chk("slverr", 32'(err_q), 32'(rows[i].err));
    end
    // Data write: zero to trigger must not abort
    apb(1'b1, 8'h00, 32'h0000_0006, r);
    t0 = cyc;
    apb(1'b1, 8'h00, 32'h0000_0004, r);
    apb(1'b0, 8'h00, ZERO, r);
    chk("busy", r, 32'h0000_0006);
    wait_idle();
    chk("write time", 32'(cyc - t0 >= WR_US * eec_pkg::US_CYCLES), 32'h0000_0001);
    chk("trigger cleared", r, 32'h0000_0004);
    apb(1'b0, 8'h14, ZERO, r);
    chk("done flag", r, 32'h0000_0001);
    repeat (4) @(posedge clock);
    chk("irq high", 32'(irq), 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_0001, r);
    repeat (2) @(posedge clock);
    chk("irq low", 32'(irq), ZERO);
    // Read back the written byte: address, clear selects, then trigger
    apb(1'b1, 8'h0C, ZERO, r);
    apb(1'b1, 8'h08, 32'h0000_0002, r);
    apb(1'b1, 8'h04, 32'h0000_00A5, r);
    apb(1'b1, 8'h00, ZERO, r);
    apb(1'b1, 8'h00, 32'h0000_0001, r);
    apb(1'b0, 8'h0C, ZERO, r);
    chk("read byte", r, 32'h0000_003C);
    apb(1'b0, 8'h00, ZERO, r);
    chk("read clears", r, ZERO);
    apb(1'b0, 8'h0C, ZERO, r);
    chk("hold", r, 32'h0000_003C);
    apb(1'b0, 8'h14, ZERO, r);
    chk("read done flag", r, 32'h0000_0002);
    // Read refused while program memory is selected
    apb(1'b1, 8'h0C, 32'h0000_0077, r);
    apb(1'b1, 8'h00, 32'h0000_0080, r);
    apb(1'b1, 8'h00, 32'h0000_0081, r);
    apb(1'b0, 8'h00, ZERO, r);
    chk("read refused", r, 32'h0000_0080);
    apb(1'b0, 8'h0C, ZERO, r);
    chk("data kept", r, 32'h0000_0077);
    // Program memory write ends in one strobe
    apb(1'b1, 8'h00, 32'h0000_0084, r);
    apb(1'b1, 8'h00, 32'h0000_0086, r);
    wait_idle();
    chk("prog strobe", 32'(strobes), 32'h0000_0001);
    // Config space write leaves the data array alone
    apb(1'b1, 8'h0C, 32'h0000_005A, r);
    apb(1'b1, 8'h00, 32'h0000_0044, r);
    apb(1'b1, 8'h00, 32'h0000_0046, r);
    wait_idle();
    chk("cfg no strobe", 32'(strobes), 32'h0000_0001);
    apb(1'b1, 8'h00, ZERO, r);
    apb(1'b1, 8'h00, 32'h0000_0001, r);
    apb(1'b0, 8'h0C, ZERO, r);
    chk("cfg array kept", r, 32'h0000_003C);
    apb(1'b1, 8'h14, 32'h0000_0007, r);
    // Both reset sources interrupt a running write
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 8'h00, 32'h0000_0004, r);
      apb(1'b1, 8'h00, 32'h0000_0006, r);
      repeat (10) @(posedge clock);
      if (s == 0) master_clear_reset <= 1'b1;
      else watchdog_timeout <= 1'b1;
      repeat (4) @(posedge clock);
      master_clear_reset <= 1'b0;
      watchdog_timeout <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1'b0, 8'h00, ZERO, r);
      chk("abort flag", r, 32'h0000_0008);
      apb(1'b0, 8'h14, ZERO, r);
      chk("abort irq", r, 32'h0000_0004);
      apb(1'b0, 8'h04, ZERO, r);
      chk("addr zeroed", r, ZERO);
      apb(1'b0, 8'h0C, ZERO, r);
      chk("data zeroed", r, ZERO);
      apb(1'b1, 8'h14, 32'h0000_0007, r);
      apb(1'b1, 8'h00, ZERO, r);
    end
    // Mid-run reset returns the address pair to zero
    apb(1'b1, 8'h08, 32'h0000_0003, r);
    apb(1'b1, 8'h04, 32'h0000_005A, r);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, 8'h04, ZERO, r);
    chk("rst addr low", r, ZERO);
    apb(1'b0, 8'h08, ZERO, r);
    chk("rst addr high", r, ZERO);
    summarize();
  end
endmodule
